// ===== hw/mac_counter.sv
// Ten-bit acquisition address counter with split parallel load
`timescale 1ns/100ps
`default_nettype none
module mac_counter #(
    parameter int CNT_W = mac_pkg::CNT_W,
    parameter int LOW_W = mac_pkg::LOW_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Counter clock and load control
    input wire logic i_count_pulse,
    input wire logic i_low_load_n,
    input wire logic i_high_load_n,
    input wire logic [LOW_W-1:0] i_load_data,
    // Count value
    output logic [CNT_W-1:0] o_count
);
    logic [CNT_W-1:0] next_count;

    // Load either part, otherwise count with wrap
    always_comb begin
        next_count = o_count;
        if (i_count_pulse) begin
            if (!i_low_load_n || !i_high_load_n) begin
                if (!i_low_load_n) begin
                    next_count[LOW_W-1:0] = i_load_data;
                end
                if (!i_high_load_n) begin
                    next_count[CNT_W-1:LOW_W] = i_load_data[CNT_W-LOW_W-1:0];
                end
            end else begin
                next_count = o_count + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count <= '0;
        end else begin
            o_count <= next_count;
        end
    end

    // Load and count checks
    a_low_part_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_count_pulse && !i_low_load_n |=> o_count[LOW_W-1:0] == $past(i_load_data))
        else $error("low byte not loaded on counter clock");
    a_high_part_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_count_pulse && !i_high_load_n
        |=> o_count[CNT_W-1:LOW_W] == $past(i_load_data[CNT_W-LOW_W-1:0]))
        else $error("high bits not loaded on counter clock");
    a_count_step_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_count_pulse && i_low_load_n && i_high_load_n
        |=> o_count == CNT_W'($past(o_count) + 1'b1))
        else $error("counter did not step by one");
    a_count_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_count_pulse |=> $stable(o_count))
        else $error("counter moved without a counter clock");
endmodule
`default_nettype wire

// ===== hw/mac_pkg.sv
// Constants for the acquisition address counter block
package mac_pkg;
    // Counter geometry
    localparam int CNT_W = 10;
    localparam int LOW_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CLK_REGS = 6;
    localparam int SYNC_W = 33;

    // I/O port addresses
    localparam logic [7:0] ADDR_LOW_READ = 8'h03;
    localparam logic [7:0] ADDR_HIGH_READ = 8'h04;
    localparam logic [7:0] ADDR_LOAD_CTRL = 8'h10;
    localparam logic [7:0] ADDR_MEM_CTRL = 8'h11;
    localparam logic [7:0] ADDR_SINGLE_STEP = 8'h12;

    // Reset values
    localparam logic [7:0] LOAD_CTRL_RESET = 8'hff;
    localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLK_REG_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Field positions
    localparam int LOAD_LOW_BIT = 3;
    localparam int LOAD_HIGH_BIT = 4;
    localparam int MEM_READ_BIT = 5;
    localparam int CLK_SEL_REG = 4;
    localparam int CLK_SEL_STEP_BIT = 7;
endpackage

// ===== hw/mac_top.sv
// Acquisition address counter: host latches, clock select, readback
`timescale 1ns/100ps
`default_nettype none
module mac_top #(
    parameter int DATA_W = mac_pkg::DATA_W,
    parameter int CNT_W = mac_pkg::CNT_W,
    parameter int NUM_CLK_REGS = mac_pkg::NUM_CLK_REGS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Host I/O bus pins
    input wire logic i_io_wr_n,
    input wire logic i_io_rd_n,
    input wire logic [7:0] i_io_addr,
    input wire logic [DATA_W-1:0] i_host_data_lines,
    output logic [DATA_W-1:0] o_host_data_lines,
    output logic o_host_data_lines_oe,
    // Parallel control strobes, clock select is one of them
    input wire logic [NUM_CLK_REGS-1:0] i_parallel_control_strobes_n,
    // Local bus and free-running sample clock request
    input wire logic [7:0] i_local_bus_bits,
    input wire logic i_sample_clock_req,
    // Counter control and status
    output logic o_low_byte_load_n,
    output logic o_high_bits_load_n,
    output logic o_mem_read,
    output logic o_counter_enable_n,
    output logic o_main_sample_clock,
    output logic o_counter_clock,
    output logic o_high_readback_select_n,
    output logic [CNT_W-1:0] o_acq_addr_counter
);
    // Two-stage synchroniser on every pin input
    logic [mac_pkg::SYNC_W-1:0] sync_meta;
    logic [mac_pkg::SYNC_W-1:0] sync_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_meta <= {mac_pkg::SYNC_W{1'b1}};
            sync_q <= {mac_pkg::SYNC_W{1'b1}};
        end else begin
            sync_meta <= {i_io_wr_n, i_io_rd_n, i_io_addr, i_host_data_lines,
                          i_parallel_control_strobes_n, i_local_bus_bits,
                          i_sample_clock_req};
            sync_q <= sync_meta;
        end
    end

    // Synchronised fields
    logic wr_n_s;
    logic rd_n_s;
    logic [7:0] addr_s;
    logic [DATA_W-1:0] data_s;
    logic [NUM_CLK_REGS-1:0] pcs_n_s;
    logic [7:0] local_bus_s;
    logic sample_s;
    assign {wr_n_s, rd_n_s, addr_s, data_s, pcs_n_s, local_bus_s, sample_s} = sync_q;

    // Edge history
    logic wr_n_prev;
    logic sample_prev;
    logic [NUM_CLK_REGS-1:0] pcs_n_prev;
    logic wr_fall;
    logic sample_rise;
    assign wr_fall = wr_n_prev && !wr_n_s;
    assign sample_rise = !sample_prev && sample_s;

    // Write decode, taken on the falling edge of the write strobe
    logic wr_load_ctrl;
    logic wr_mem_ctrl;
    logic wr_single_step;
    assign wr_load_ctrl = wr_fall && (addr_s == mac_pkg::ADDR_LOAD_CTRL);
    assign wr_mem_ctrl = wr_fall && (addr_s == mac_pkg::ADDR_MEM_CTRL);
    assign wr_single_step = wr_fall && (addr_s == mac_pkg::ADDR_SINGLE_STEP);

    // Read decode; a read is live while the read strobe stays low
    logic rd_active;
    logic rd_low;
    logic rd_high;
    assign rd_active = !rd_n_s;
    assign rd_low = rd_active && (addr_s == mac_pkg::ADDR_LOW_READ);
    assign rd_high = rd_active && (addr_s == mac_pkg::ADDR_HIGH_READ);

    // Clock configuration registers, one per control strobe
    logic [DATA_W-1:0] clk_regs [NUM_CLK_REGS];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CLK_REGS; gi++) begin : g_clk_reg
            logic [DATA_W-1:0] next_reg;
            // Capture host data on the strobe's low-going edge
            assign next_reg = (pcs_n_prev[gi] && !pcs_n_s[gi]) ? data_s : clk_regs[gi];
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    clk_regs[gi] <= mac_pkg::CLK_REG_RESET;
                end else begin
                    clk_regs[gi] <= next_reg;
                end
            end
        end
    endgenerate

    // Clock source choice from the clock-select register
    logic step_selected;
    assign step_selected = clk_regs[mac_pkg::CLK_SEL_REG][mac_pkg::CLK_SEL_STEP_BIT];

    // Control latches and pulse generation
    logic [DATA_W-1:0] load_ctrl;
    logic [DATA_W-1:0] mem_ctrl;
    logic [DATA_W-1:0] next_load_ctrl;
    logic [DATA_W-1:0] next_mem_ctrl;
    logic next_main_clk;
    logic next_cnt_clk;
    logic [DATA_W-1:0] next_host_data;
    logic next_host_oe;
    logic [CNT_W-1:0] count;

    always_comb begin
        next_load_ctrl = load_ctrl;
        next_mem_ctrl = mem_ctrl;
        if (wr_load_ctrl) begin
            next_load_ctrl = data_s;
        end
        if (wr_mem_ctrl) begin
            next_mem_ctrl = data_s;
        end
        // A step write only clocks when the step source is chosen
        next_main_clk = step_selected ? wr_single_step : sample_rise;
        // Counter clock is gated off while the enable is high
        next_cnt_clk = next_main_clk && !o_counter_enable_n;
        next_host_oe = rd_active;
        next_host_data = mac_pkg::READ_IDLE;
        if (rd_low) begin
            next_host_data = count[7:0];
        end else if (rd_high) begin
            next_host_data = {{(DATA_W-CNT_W+8){1'b0}}, count[CNT_W-1:8]};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_n_prev <= 1'b1;
            sample_prev <= 1'b1;
            pcs_n_prev <= {NUM_CLK_REGS{1'b1}};
            load_ctrl <= mac_pkg::LOAD_CTRL_RESET;
            mem_ctrl <= mac_pkg::MEM_CTRL_RESET;
            o_main_sample_clock <= 1'b0;
            o_counter_clock <= 1'b0;
            o_host_data_lines <= mac_pkg::READ_IDLE;
            o_host_data_lines_oe <= 1'b0;
        end else begin
            wr_n_prev <= wr_n_s;
            sample_prev <= sample_s;
            pcs_n_prev <= pcs_n_s;
            load_ctrl <= next_load_ctrl;
            mem_ctrl <= next_mem_ctrl;
            o_main_sample_clock <= next_main_clk;
            o_counter_clock <= next_cnt_clk;
            o_host_data_lines <= next_host_data;
            o_host_data_lines_oe <= next_host_oe;
        end
    end

    // Latch bits drive the strobes directly, as the board wiring does
    assign o_low_byte_load_n = load_ctrl[mac_pkg::LOAD_LOW_BIT];
    assign o_high_bits_load_n = load_ctrl[mac_pkg::LOAD_HIGH_BIT];
    assign o_mem_read = mem_ctrl[mac_pkg::MEM_READ_BIT];
    assign o_counter_enable_n = !o_mem_read;
    assign o_high_readback_select_n = !rd_high;
    assign o_acq_addr_counter = count;

    // Counter, loaded from the synchronised local bus
    mac_counter #(
        .CNT_W(CNT_W),
        .LOW_W(mac_pkg::LOW_W)
    ) u_counter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_count_pulse(o_counter_clock),
        .i_low_load_n(o_low_byte_load_n),
        .i_high_load_n(o_high_bits_load_n),
        .i_load_data(local_bus_s),
        .o_count(count)
    );

    // Step write followed by the two clock pulses
    sequence step_write_enabled;
        wr_single_step && step_selected && !o_counter_enable_n;
    endsequence
    sequence one_pulse_pair;
        (o_main_sample_clock && o_counter_clock) ##1 (!o_main_sample_clock && !o_counter_clock);
    endsequence

    a_low_load_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_load_ctrl && data_s == 8'hf7 |=> !o_low_byte_load_n && o_high_bits_load_n)
        else $error("F7 did not drive low-byte load low");
    a_high_load_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_load_ctrl && data_s == 8'hef |=> !o_high_bits_load_n && o_low_byte_load_n)
        else $error("EF did not drive high-bits load low");
    a_count_mode_ff: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_load_ctrl && data_s == 8'hff |=> o_low_byte_load_n && o_high_bits_load_n)
        else $error("FF did not release both load strobes");
    a_mem_read_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_mem_ctrl && data_s == 8'h20 |=> o_mem_read && !o_counter_enable_n)
        else $error("20 did not enable counter clocks");
    a_step_one_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        step_write_enabled |=> one_pulse_pair)
        else $error("step write did not give one pulse pair");
    a_step_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !step_selected && !sample_rise |=> !o_main_sample_clock)
        else $error("master clock pulsed without a selected source");
    a_low_readback: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_low |=> o_host_data_lines_oe && o_host_data_lines == $past(count[7:0]))
        else $error("port 03 did not return the low byte");
    a_high_readback: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_high && !o_high_readback_select_n
        |=> o_host_data_lines == {6'h00, $past(count[CNT_W-1:8])})
        else $error("port 04 did not return the high bits");
endmodule
`default_nettype wire

// ===== verification/mac_host.sv
// Host controller model for the counter block's I/O bus and control strobes
`timescale 1ns/100ps
`default_nettype none
module mac_host (
    // Clock
    input wire logic i_clk,
    // Bus driven by the host
    output var logic o_wr_n,
    output var logic o_rd_n,
    output var logic [7:0] o_addr,
    output var logic [7:0] o_data,
    output var logic [5:0] o_ctl_n,
    // Read return
    input wire logic [7:0] i_data,
    input wire logic i_oe,
    input wire logic i_sel_n
);
    // Idle bus at time zero, all strobes high
    initial begin
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_addr = 8'h00;
        o_data = 8'ha5;
        o_ctl_n = 6'h3f;
    end
    // Pins only move at falling edges
    task automatic gap(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Write cycle; released data lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_addr = a;
        o_data = d;
        gap(3);
        o_wr_n = 1'b0;
        gap(4);
        o_wr_n = 1'b1;
        gap(1);
        o_data = ~d;
        gap(3);
    endtask
    // Control strobe k loads one byte
    task automatic ctl(input int k, input logic [7:0] d);
        o_data = d;
        gap(3);
        o_ctl_n[k] = 1'b0;
        gap(4);
        o_ctl_n[k] = 1'b1;
        gap(1);
        o_data = ~d;
        gap(3);
    endtask
    // Read cycle; answer taken while the strobe is still held
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe,
                      output logic sel_n);
        o_addr = a;
        gap(3);
        o_rd_n = 1'b0;
        gap(5);
        d = i_data;
        oe = i_oe;
        sel_n = i_sel_n;
        o_rd_n = 1'b1;
        gap(4);
    endtask
    // Done once ahead of any test loop; memory control and clock select are rewritten later too
    task automatic setup;
        for (int k = 0; k < 6; k++) ctl(k, 8'h00);
        ctl(mac_pkg::CLK_SEL_REG, 8'h80);
        wr(mac_pkg::ADDR_MEM_CTRL, 8'h20);
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the acquisition address counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_n, rd_n, oe, sreq, low_ld_n, high_ld_n, mem_rd, en_n, mclk, cclk, sel_n;
    logic [7:0] addr, hdata, rdata, lbus;
    logic [5:0] ctl_n;
    logic [9:0] cnt;
    int fail_count = 0;
    int checked = 0;
    int mclk_n = 0;
    int cclk_n = 0;

    always #50 clk = ~clk;

    mac_top u_mac_top (.i_clk(clk), .i_rst_n(rst_n), .i_io_wr_n(wr_n), .i_io_rd_n(rd_n),
        .i_io_addr(addr), .i_host_data_lines(hdata), .o_host_data_lines(rdata),
        .o_host_data_lines_oe(oe), .i_parallel_control_strobes_n(ctl_n),
        .i_local_bus_bits(lbus), .i_sample_clock_req(sreq), .o_low_byte_load_n(low_ld_n),
        .o_high_bits_load_n(high_ld_n), .o_mem_read(mem_rd), .o_counter_enable_n(en_n),
        .o_main_sample_clock(mclk), .o_counter_clock(cclk),
        .o_high_readback_select_n(sel_n), .o_acq_addr_counter(cnt));
    mac_host u_mac_host (.i_clk(clk), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr),
        .o_data(hdata), .o_ctl_n(ctl_n), .i_data(rdata), .i_oe(oe), .i_sel_n(sel_n));

    // Pulse tallies at falling edges, where the registered pulses have settled
    always @(negedge clk) begin
        if (mclk === 1'b1) mclk_n++;
        if (cclk === 1'b1) cclk_n++;
    end

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Single-step write, then pulse counts compared
    task automatic step(input int em, input int ec);
        int m0;
        int c0;
        m0 = mclk_n;
        c0 = cclk_n;
        u_mac_host.wr(mac_pkg::ADDR_SINGLE_STEP, 8'h00);
        chk("main pulses", 10'(em), 10'(mclk_n - m0));
        chk("counter pulses", 10'(ec), 10'(cclk_n - c0));
    endtask
    // Read a port and compare data, enable and high select
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, output logic bad);
        logic [7:0] d;
        logic o;
        logic s;
        u_mac_host.rd(a, d, o, s);
        bad = (d !== exp);
        chk("read data", {2'h0, exp}, {2'h0, d});
        chk("read enable", 10'h001, {9'h000, o});
        chk("high select", {9'h000, a != mac_pkg::ADDR_HIGH_READ}, {9'h000, s});
    endtask
    // Ten-bit load in two parts; spare bus bits set to prove they are ignored
    task automatic loadc(input logic [9:0] v);
        u_mac_host.wr(mac_pkg::ADDR_LOAD_CTRL, 8'hf7);
        lbus = v[7:0];
        step(1, 1);
        u_mac_host.wr(mac_pkg::ADDR_LOAD_CTRL, 8'hef);
        lbus = {6'h2a, v[9:8]};
        step(1, 1);
        u_mac_host.wr(mac_pkg::ADDR_LOAD_CTRL, 8'hff);
        chk("loaded value", v, cnt);
    endtask

    task automatic t_reset;
        chk("load strobes", 10'h003, {8'h00, low_ld_n, high_ld_n});
        chk("mem read and enable", 10'h001, {8'h00, mem_rd, en_n});
        chk("counter", 10'h000, cnt);
        $display("t_reset done");
    endtask
    task automatic t_setup;
        u_mac_host.setup();
        chk("mem read and enable", 10'h002, {8'h00, mem_rd, en_n});
        $display("t_setup done");
    endtask
    task automatic t_low_walk;
        logic bad;
        u_mac_host.wr(mac_pkg::ADDR_LOAD_CTRL, 8'hf7);
        chk("load strobes", 10'h001, {8'h00, low_ld_n, high_ld_n});
        for (int i = 0; i < 8; i++) begin
            lbus = 8'h80 >> i;
            step(1, 1);
            rdc(mac_pkg::ADDR_LOW_READ, 8'h80 >> i, bad);
        end
        $display("t_low_walk done");
    endtask
    task automatic t_high_walk;
        logic bad;
        u_mac_host.wr(mac_pkg::ADDR_LOAD_CTRL, 8'hef);
        chk("load strobes", 10'h002, {8'h00, low_ld_n, high_ld_n});
        for (int i = 0; i < 2; i++) begin
            lbus = 8'hfc | (8'h02 >> i);
            step(1, 1);
            rdc(mac_pkg::ADDR_HIGH_READ, 8'h02 >> i, bad);
            if (bad) break;
        end
        rdc(mac_pkg::ADDR_LOW_READ, 8'h01, bad);
        $display("t_high_walk done");
    endtask
    task automatic t_count;
        logic bad;
        loadc(10'h3fe);
        chk("load strobes", 10'h003, {8'h00, low_ld_n, high_ld_n});
        step(1, 1);
        chk("counter", 10'h3ff, cnt);
        step(1, 1);
        chk("counter", 10'h000, cnt);
        loadc(10'h0ff);
        step(1, 1);
        rdc(mac_pkg::ADDR_LOW_READ, 8'h00, bad);
        rdc(mac_pkg::ADDR_HIGH_READ, 8'h01, bad);
        $display("t_count done");
    endtask
    task automatic t_refuse;
        logic bad;
        int c0;
        int m0;
        c0 = cclk_n;
        rdc(8'h55, 8'h00, bad);
        sreq = 1'b1;
        u_mac_host.gap(6);
        sreq = 1'b0;
        u_mac_host.gap(6);
        chk("free clock ignored", 10'h000, 10'(cclk_n - c0));
        u_mac_host.wr(mac_pkg::ADDR_MEM_CTRL, 8'h00);
        chk("mem read and enable", 10'h001, {8'h00, mem_rd, en_n});
        step(1, 0);
        chk("counter held", 10'h100, cnt);
        u_mac_host.wr(mac_pkg::ADDR_MEM_CTRL, 8'h20);
        step(1, 1);
        chk("counter", 10'h101, cnt);
        // Free-running source chosen: step writes go dead, request edges clock
        u_mac_host.ctl(mac_pkg::CLK_SEL_REG, 8'h00);
        step(0, 0);
        m0 = mclk_n;
        c0 = cclk_n;
        sreq = 1'b1;
        u_mac_host.gap(6);
        sreq = 1'b0;
        u_mac_host.gap(6);
        chk("free clock main", 10'h001, 10'(mclk_n - m0));
        chk("free clock counter", 10'h001, 10'(cclk_n - c0));
        chk("counter", 10'h102, cnt);
        u_mac_host.ctl(mac_pkg::CLK_SEL_REG, 8'h80);
        $display("t_refuse done");
    endtask

    // Main sequence: inputs move only at falling edges
    initial begin
        lbus = 8'h00;
        sreq = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_setup();
        t_low_walk();
        t_high_walk();
        t_count();
        t_refuse();
        finish_test();
    end
    // Watchdog, several times the expected run length
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
